// ==== i2crd_pkg.sv ====
// constants and types shared by the i2c register read slave
package i2crd_pkg;
  // ---------------------------------------------------------------
  // link addressing and framing
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR_BASE  = 7'h68;
  localparam int         SEL_W      = 3;
  localparam logic       DIR_READ   = 1'b1;
  localparam logic [3:0] LAST_BIT   = 4'h7;
  localparam logic [3:0] ACK_SLOT   = 4'h8;
  localparam logic [3:0] FIRST_CNT  = 4'h1;
  // ---------------------------------------------------------------
  // command byte layout
  // ---------------------------------------------------------------
  localparam logic [2:0] OP_READ    = 3'h4;
  localparam int         OP_MSB     = 2;
  localparam int         B1_PS_MSB  = 3;
  localparam int         B2_PS_BIT  = 7;
  localparam int         B2_BE_MSB  = 5;
  localparam int         B2_BE_LSB  = 2;
  localparam int         B2_AD_MSB  = 1;
  localparam logic [1:0] CMD_B0     = 2'h0;
  localparam logic [1:0] CMD_B1     = 2'h1;
  localparam logic [1:0] CMD_B2     = 2'h2;
  localparam logic [1:0] CMD_B3     = 2'h3;
  // ---------------------------------------------------------------
  // widths and read data
  // ---------------------------------------------------------------
  localparam int         DATA_W     = 32;
  localparam int         RADDR_W    = 10;
  localparam int         PORT_W     = 5;
  localparam int         BE_W       = 4;
  localparam logic [1:0] FIRST_BYTE = 2'h3;
  localparam logic [7:0] FILL_BYTE  = 8'hff;
  // ---------------------------------------------------------------
  // link state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    LK_IDLE,
    LK_ADDR,
    LK_CMD,
    LK_READ,
    LK_IGNORE
  } i2crd_link_t;
endpackage : i2crd_pkg

// ==== i2crd_sync.sv ====
// two flip-flop level synchroniser
`timescale 1ns/10ps
module i2crd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,   // destination clock
  input  wire logic         rst,   // asynchronous reset, active high
  input  wire logic [W-1:0] d,     // level from the other domain
  output logic      [W-1:0] q      // synchronised level
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : i2crd_sync

// ==== i2crd_start.sv ====
// start condition detector on the falling data line
`timescale 1ns/10ps
module i2crd_start (
  input  wire logic sda_in,     // data line level
  input  wire logic scl,        // link clock level
  input  wire logic rst,        // asynchronous reset, active high
  output logic      start_tog   // flips on every start condition
);
  // a falling data line while the clock is high marks a start;
  // the toggle is read at the next rising link clock, one bit period later
  always_ff @(negedge sda_in or posedge rst) begin
    if (rst) begin
      start_tog <= 1'b0;
    end else if (scl) begin
      start_tog <= ~start_tog;
    end
  end
endmodule : i2crd_start

// ==== i2crd_slave.sv ====
// i2c register read slave: link engine, command crossing and register fetch
`timescale 1ns/10ps
// Summary of operation
// - four command bytes follow the write address; each one is acknowledged.
// - byte 0 bits 2..0 hold the opcode; 100b means register read.
// - byte 2 bits 5..2 carry four byte enables; bit 6 reserved.
// - dword address is byte 2 bits 1..0 above byte 3 bits 7..0.
// - read data goes out byte 3 first, byte 0 last.
// - slave answers address 68h with its three select pins giving low bits.
// - byte 1 bits 3..0 and byte 2 bit 7 form the port select.
// - after the command the addressed register is loaded into a buffer.
// - reading beyond four bytes repeats the sequence from byte 3.
// - a repeated start may join both packets; it is accepted.
module i2crd_slave (
  input  wire logic                          clk,             // system clock, 40 mhz
  input  wire logic                          rst,             // async reset, active high
  input  wire logic                          scl,             // link clock from the master
  input  wire logic                          sda_in,          // data line level
  output logic                               sda_out,         // data line drive value
  output logic                               sda_oe,          // high while pulling data low
  input  wire logic [i2crd_pkg::SEL_W-1:0]   addr_sel,        // address select pins
  output logic                               reg_rd_req,      // register fetch pulse
  output logic [i2crd_pkg::PORT_W-1:0]       reg_rd_port,     // selected switch port
  output logic [i2crd_pkg::RADDR_W-1:0]      reg_rd_addr,     // register dword address
  output logic [i2crd_pkg::BE_W-1:0]         reg_rd_be,       // byte enables
  input  wire logic                          reg_rd_ack,      // fetch answer strobe
  input  wire logic [i2crd_pkg::DATA_W-1:0]  reg_rd_data,     // fetched register word
  output logic                               rd_busy,         // fetch outstanding
  output logic                               cmd_unsupported  // last command not a read
);
  // ---------------------------------------------------------------
  // link domain signals
  // ---------------------------------------------------------------
  i2crd_pkg::i2crd_link_t              lk_state;
  logic                                start_tog;
  logic                                start_seen;
  logic                                new_frame;
  logic [3:0]                          bit_cnt;
  logic [6:0]                          shift;
  logic [7:0]                          rx_byte;
  logic                                ack_pend;
  logic [1:0]                          byte_idx;
  logic [i2crd_pkg::SEL_W-1:0]         sel_s;
  logic                                addr_hit;
  logic [2:0]                          cmd_op;
  logic [i2crd_pkg::PORT_W-1:0]        cmd_port;
  logic [i2crd_pkg::BE_W-1:0]          cmd_be;
  logic [i2crd_pkg::RADDR_W-1:0]       cmd_addr;
  logic                                req_tog;
  logic                                done_s;
  logic [i2crd_pkg::DATA_W-1:0]        rd_word;
  logic [1:0]                          rd_ptr;
  logic                                tx_bit;
  // ---------------------------------------------------------------
  // system domain signals
  // ---------------------------------------------------------------
  logic                                req_s;
  logic                                req_seen;
  logic                                new_cmd;
  logic                                done_tog;
  logic [i2crd_pkg::DATA_W-1:0]        rd_buf;

  i2crd_start u_start (
    .sda_in    (sda_in),
    .scl       (scl),
    .rst       (rst),
    .start_tog (start_tog)
  );

  i2crd_sync #(.W(i2crd_pkg::SEL_W)) u_sel_sync (
    .clk (scl),
    .rst (rst),
    .d   (addr_sel),
    .q   (sel_s)
  );

  i2crd_sync #(.W(1)) u_done_sync (
    .clk (scl),
    .rst (rst),
    .d   (done_tog),
    .q   (done_s)
  );

  i2crd_sync #(.W(1)) u_req_sync (
    .clk (clk),
    .rst (rst),
    .d   (req_tog),
    .q   (req_s)
  );

  // ---------------------------------------------------------------
  // link framing and byte engine
  // ---------------------------------------------------------------
  assign new_frame = start_tog != start_seen;
  assign rx_byte   = {shift, sda_in};
  assign addr_hit  = rx_byte[7:1] == {i2crd_pkg::ADDR_BASE[6:3], sel_s};
  assign tx_bit    = rd_word[{rd_ptr, ~bit_cnt[2:0]}];

  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      start_seen <= 1'b0;
      lk_state   <= i2crd_pkg::LK_IDLE;
      bit_cnt    <= 4'h0;
      shift      <= 7'h00;
      ack_pend   <= 1'b0;
      byte_idx   <= 2'h0;
    end else begin
      start_seen <= start_tog;
      if (new_frame) begin
        lk_state <= i2crd_pkg::LK_ADDR;
        bit_cnt  <= i2crd_pkg::FIRST_CNT;
        shift    <= {6'h00, sda_in};
        ack_pend <= 1'b0;
      end else if (bit_cnt == i2crd_pkg::ACK_SLOT) begin
        bit_cnt  <= 4'h0;
        ack_pend <= 1'b0;
        // a not-acknowledge from the master ends the read burst
        if (lk_state == i2crd_pkg::LK_READ && sda_in) begin
          lk_state <= i2crd_pkg::LK_IGNORE;
        end
      end else begin
        bit_cnt <= 4'(bit_cnt + 4'h1);
        shift   <= {shift[5:0], sda_in};
        if (bit_cnt == i2crd_pkg::LAST_BIT) begin
          unique case (lk_state)
            i2crd_pkg::LK_ADDR: begin
              byte_idx <= 2'h0;
              if (addr_hit) begin
                ack_pend <= 1'b1;
                lk_state <= (rx_byte[0] == i2crd_pkg::DIR_READ) ?
                            i2crd_pkg::LK_READ : i2crd_pkg::LK_CMD;
              end else begin
                lk_state <= i2crd_pkg::LK_IGNORE;
              end
            end
            i2crd_pkg::LK_CMD: begin
              ack_pend <= 1'b1;
              byte_idx <= 2'(byte_idx + 2'h1);
              // the write path is not here, so bytes past the fourth get no answer
              if (byte_idx == i2crd_pkg::CMD_B3) begin
                lk_state <= i2crd_pkg::LK_IGNORE;
              end
            end
            i2crd_pkg::LK_IDLE, i2crd_pkg::LK_READ, i2crd_pkg::LK_IGNORE: begin
            end
          endcase
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // command field capture
  // ---------------------------------------------------------------
  // fields stay put until the next command, long after the system side took them
  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      cmd_op   <= 3'h0;
      cmd_port <= 5'h00;
      cmd_be   <= 4'h0;
      cmd_addr <= 10'h000;
      req_tog  <= 1'b0;
    end else if (!new_frame && bit_cnt == i2crd_pkg::LAST_BIT &&
                 lk_state == i2crd_pkg::LK_CMD) begin
      unique case (byte_idx)
        i2crd_pkg::CMD_B0: cmd_op <= rx_byte[i2crd_pkg::OP_MSB:0];
        i2crd_pkg::CMD_B1: cmd_port[4:1] <= rx_byte[i2crd_pkg::B1_PS_MSB:0];
        i2crd_pkg::CMD_B2: begin
          cmd_port[0]  <= rx_byte[i2crd_pkg::B2_PS_BIT];
          cmd_be       <= rx_byte[i2crd_pkg::B2_BE_MSB:i2crd_pkg::B2_BE_LSB];
          cmd_addr[9:8] <= rx_byte[i2crd_pkg::B2_AD_MSB:0];
        end
        i2crd_pkg::CMD_B3: begin
          cmd_addr[7:0] <= rx_byte;
          req_tog       <= ~req_tog;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read word and byte pointer
  // ---------------------------------------------------------------
  // if the fetch has not come back by the read address, all ones go out
  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      rd_word <= 32'h0000_0000;
      rd_ptr  <= i2crd_pkg::FIRST_BYTE;
    end else if (!new_frame) begin
      if (bit_cnt == i2crd_pkg::LAST_BIT && lk_state == i2crd_pkg::LK_ADDR &&
          addr_hit && rx_byte[0] == i2crd_pkg::DIR_READ) begin
        rd_word <= (done_s == req_tog) ? rd_buf : {4{i2crd_pkg::FILL_BYTE}};
        rd_ptr  <= i2crd_pkg::FIRST_BYTE;
      end else if (bit_cnt == i2crd_pkg::ACK_SLOT && !ack_pend &&
                   lk_state == i2crd_pkg::LK_READ && !sda_in) begin
        // ack_pend marks our own address acknowledge, which must not advance the pointer
        rd_ptr <= 2'(rd_ptr - 2'h1);
      end
    end
  end

  // ---------------------------------------------------------------
  // data line drive on the falling link clock
  // ---------------------------------------------------------------
  always_ff @(negedge scl or posedge rst) begin
    if (rst) begin
      sda_oe  <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      if (bit_cnt == i2crd_pkg::ACK_SLOT) begin
        sda_oe <= ack_pend;
      end else if (lk_state == i2crd_pkg::LK_READ) begin
        sda_oe <= ~tx_bit;
      end else begin
        sda_oe <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // system side: command decode and register fetch
  // ---------------------------------------------------------------
  assign new_cmd = (req_s != req_seen) && !rd_busy;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_seen        <= 1'b0;
      reg_rd_req      <= 1'b0;
      reg_rd_port     <= 5'h00;
      reg_rd_addr     <= 10'h000;
      reg_rd_be       <= 4'h0;
      rd_busy         <= 1'b0;
      done_tog        <= 1'b0;
      cmd_unsupported <= 1'b0;
    end else begin
      reg_rd_req <= 1'b0;
      if (new_cmd) begin
        req_seen <= req_s;
        if (cmd_op == i2crd_pkg::OP_READ) begin
          reg_rd_req      <= 1'b1;
          reg_rd_port     <= cmd_port;
          reg_rd_addr     <= cmd_addr;
          reg_rd_be       <= cmd_be;
          rd_busy         <= 1'b1;
          cmd_unsupported <= 1'b0;
        end else begin
          cmd_unsupported <= 1'b1;
          done_tog        <= ~done_tog;
        end
      end else if (rd_busy && reg_rd_ack) begin
        rd_busy  <= 1'b0;
        done_tog <= ~done_tog;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_buf <= 32'h0000_0000;
    end else if (rd_busy && reg_rd_ack) begin
      rd_buf <= reg_rd_data;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  addr_ack_a: assert property (@(posedge scl) disable iff (rst)
    (!new_frame && lk_state == i2crd_pkg::LK_ADDR && bit_cnt == i2crd_pkg::LAST_BIT
     && addr_hit) |=> (sda_oe && bit_cnt == i2crd_pkg::ACK_SLOT))
    else $error("matching address not acknowledged");
  addr_miss_a: assert property (@(posedge scl) disable iff (rst)
    (!new_frame && lk_state == i2crd_pkg::LK_ADDR && bit_cnt == i2crd_pkg::LAST_BIT
     && !addr_hit) |=> !sda_oe ##1 (lk_state == i2crd_pkg::LK_IGNORE || new_frame))
    else $error("foreign address acknowledged");
  cmd_ack_a: assert property (@(posedge scl) disable iff (rst)
    (!new_frame && lk_state == i2crd_pkg::LK_CMD && bit_cnt == i2crd_pkg::LAST_BIT)
    |=> sda_oe)
    else $error("command byte not acknowledged");
  read_first_a: assert property (@(posedge scl) disable iff (rst)
    $rose(lk_state == i2crd_pkg::LK_READ) |=> rd_ptr == i2crd_pkg::FIRST_BYTE)
    else $error("read burst does not open with byte 3");
  read_wrap_a: assert property (@(posedge scl) disable iff (rst)
    (!new_frame && lk_state == i2crd_pkg::LK_READ && bit_cnt == i2crd_pkg::ACK_SLOT
     && !sda_in && rd_ptr == 2'h0) |=> rd_ptr == i2crd_pkg::FIRST_BYTE)
    else $error("read burst does not wrap to byte 3");
  read_bit_a: assert property (@(posedge scl) disable iff (rst)
    (lk_state == i2crd_pkg::LK_READ && bit_cnt < i2crd_pkg::ACK_SLOT && !$past(new_frame))
    |-> sda_oe == ~rd_word[{rd_ptr, ~bit_cnt[2:0]}])
    else $error("wrong read data bit on the line");
  addr_build_a: assert property (@(posedge scl) disable iff (rst)
    (!new_frame && lk_state == i2crd_pkg::LK_CMD && bit_cnt == i2crd_pkg::LAST_BIT
     && byte_idx == i2crd_pkg::CMD_B3)
    |=> (cmd_addr[7:0] == $past(rx_byte) && req_tog != $past(req_tog)))
    else $error("dword address low part not captured");
  port_be_a: assert property (@(posedge scl) disable iff (rst)
    (!new_frame && lk_state == i2crd_pkg::LK_CMD && bit_cnt == i2crd_pkg::LAST_BIT
     && byte_idx == i2crd_pkg::CMD_B2)
    |=> (cmd_be == $past(rx_byte[5:2]) && cmd_port[0] == $past(rx_byte[7])
         && cmd_addr[9:8] == $past(rx_byte[1:0])))
    else $error("byte 2 fields not captured");
  restart_a: assert property (@(posedge scl) disable iff (rst)
    new_frame |=> (lk_state == i2crd_pkg::LK_ADDR && bit_cnt == i2crd_pkg::FIRST_CNT))
    else $error("start does not restart the address phase");
  fetch_req_a: assert property (@(posedge clk) disable iff (rst)
    (new_cmd && cmd_op == i2crd_pkg::OP_READ)
    |=> (reg_rd_req && rd_busy && reg_rd_addr == $past(cmd_addr)) ##1 !reg_rd_req)
    else $error("read command did not raise a single fetch pulse");
  op_decode_a: assert property (@(posedge clk) disable iff (rst)
    (new_cmd && cmd_op != i2crd_pkg::OP_READ) |=> (!reg_rd_req && cmd_unsupported))
    else $error("non-read command started a fetch");
  buf_load_a: assert property (@(posedge clk) disable iff (rst)
    (rd_busy && reg_rd_ack) |=> (rd_buf == $past(reg_rd_data) && !rd_busy
                                 && done_tog != $past(done_tog)))
    else $error("fetched word not loaded into the buffer");

  read_burst_c: cover property (@(posedge scl) disable iff (rst)
    $rose(lk_state == i2crd_pkg::LK_READ));
  wrap_c: cover property (@(posedge scl) disable iff (rst)
    (lk_state == i2crd_pkg::LK_READ && bit_cnt == i2crd_pkg::ACK_SLOT && !sda_in
     && rd_ptr == 2'h0));
  merged_c: cover property (@(posedge scl) disable iff (rst)
    (new_frame && lk_state == i2crd_pkg::LK_IGNORE && byte_idx == 2'h0));
  fetch_c: cover property (@(posedge clk) disable iff (rst) rd_busy && reg_rd_ack);
endmodule : i2crd_slave

// ==== i2crd_master.sv ====
// bus master model that drives the link of the register read slave
`timescale 1ns/10ps
module i2crd_master (
  output logic      scl,      // link clock, stands still outside frames
  output logic      sda_low,  // high while the master pulls data low
  input  wire logic sda_line  // resolved data line level
);
  // ---------------------------------------------------------------
  // idle bus: both lines released to the pull-ups
  // ---------------------------------------------------------------
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // ---------------------------------------------------------------
  // bit level: 6 ns link period, data changes only while scl is low
  // ---------------------------------------------------------------
  task automatic bit_out(input logic b);
    #1 sda_low = ~b;
    #2 scl = 1'b1;
    #3 scl = 1'b0;
  endtask : bit_out

  task automatic bit_in(output logic b);
    #1 sda_low = 1'b0;
    #2 scl = 1'b1;
    #1 b = sda_line;
    #2 scl = 1'b0;
  endtask : bit_in

  // ---------------------------------------------------------------
  // framing; start doubles as repeated start from a low clock
  // ---------------------------------------------------------------
  task automatic start();
    sda_low = 1'b0;
    #1 scl = 1'b1;
    #2 sda_low = 1'b1;
    #3 scl = 1'b0;
  endtask : start

  task automatic stop();
    sda_low = 1'b1;
    #2 scl = 1'b1;
    #2 sda_low = 1'b0;
    #3;
  endtask : stop

  // ---------------------------------------------------------------
  // byte level
  // ---------------------------------------------------------------
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_out(d[i]);
    end
    bit_in(b);
    ack = ~b;
  endtask : write_byte

  task automatic addr_byte(input logic [6:0] a, input logic rw, output logic ack);
    write_byte({a, rw}, ack);
  endtask : addr_byte

  // the last byte of a burst must be refused, or the slave keeps driving
  task automatic read_byte(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      bit_in(d[i]);
    end
    bit_out(~ack);
  endtask : read_byte
endmodule : i2crd_master

// ==== i2crd_slave_bench.sv ====
// self-checking bench for the i2c register read slave
`timescale 1ns/10ps
module i2crd_slave_bench;
  logic        clk, rst, scl, m_low, sda_in, sda_out, sda_oe, reg_rd_req, reg_rd_ack;
  logic        rd_busy, cmd_unsupported, ack;
  logic [2:0]  addr_sel;
  logic [4:0]  reg_rd_port, cap_port;
  logic [9:0]  reg_rd_addr, cap_addr;
  logic [3:0]  reg_rd_be, cap_be;
  logic [31:0] reg_rd_data;
  int          error_cnt, samples_checked, cyc, req_cnt, dly, prev;

  // wired-and data line with pull-up
  assign sda_in = ~(m_low | (sda_oe & ~sda_out));

  i2crd_master m (.scl(scl), .sda_low(m_low), .sda_line(sda_in));

  i2crd_slave dut (
    .clk(clk), .rst(rst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_sel(addr_sel), .reg_rd_req(reg_rd_req),
    .reg_rd_port(reg_rd_port), .reg_rd_addr(reg_rd_addr), .reg_rd_be(reg_rd_be),
    .reg_rd_ack(reg_rd_ack), .reg_rd_data(reg_rd_data), .rd_busy(rd_busy),
    .cmd_unsupported(cmd_unsupported));

  always #12.5 clk = ~clk;

  // ---------------------------------------------------------------
  // reporting
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      final_report();
    end
  end

  // ---------------------------------------------------------------
  // register side: answers each fetch four cycles late
  // ---------------------------------------------------------------
  function automatic logic [31:0] word_of(input logic [4:0] p, input logic [9:0] a);
    return {8'hc3 ^ {3'h0, p}, 6'h15, a, 8'h5a};
  endfunction : word_of

  // data bus toggles outside the ack so a stale sample cannot pass
  always @(negedge clk) begin
    if (dly > 0) dly--;
    reg_rd_ack = (dly == 1);
    if (dly == 1) begin
      reg_rd_data = word_of(cap_port, cap_addr);
    end else begin
      reg_rd_data = ~reg_rd_data;
    end
    if (reg_rd_req === 1'b1) begin
      req_cnt++;
      {cap_port, cap_addr, cap_be} = {reg_rd_port, reg_rd_addr, reg_rd_be};
      check("busy_at_req", rd_busy, 1'b1);
      dly = 5;
    end
  end

  // ---------------------------------------------------------------
  // link tasks
  // ---------------------------------------------------------------
  task automatic send_cmd(input logic [31:0] bytes);
    logic a;
    prev = req_cnt;
    m.start();
    m.addr_byte(7'h68, 1'b0, a);
    check("cmd_addr_ack", a, 1'b1);
    for (int i = 3; i >= 0; i--) begin
      m.write_byte(bytes[8 * i +: 8], a);
      check("cmd_byte_ack", a, 1'b1);
    end
  endtask : send_cmd

  task automatic wait_fetch(input logic [4:0] p, input logic [9:0] a, input logic [3:0] be);
    for (int n = 0; n < 40 && req_cnt == prev; n++) @(negedge clk);
    for (int n = 0; n < 40 && rd_busy !== 1'b0; n++) @(negedge clk);
    check("req_count", req_cnt, prev + 1);
    check("port", cap_port, p);
    check("dword_addr", cap_addr, a);
    check("byte_en", cap_be, be);
  endtask : wait_fetch

  task automatic read_back(input logic [31:0] w, input int n);
    logic       a;
    logic [7:0] d;
    m.addr_byte(7'h68, 1'b1, a);
    check("rd_addr_ack", a, 1'b1);
    for (int i = 0; i < n; i++) begin
      m.read_byte(i < n - 1, d);
      check("rd_byte", d, w[8 * (3 - i % 4) +: 8]);
    end
  endtask : read_back

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    addr_sel = 3'h0;
    reg_rd_ack = 1'b0;
    reg_rd_data = 32'h0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    // foreign address is left unanswered
    m.start();
    m.addr_byte(7'h6a, 1'b0, ack);
    check("foreign_addr_ack", ack, 1'b0);
    m.stop();
    // two packets, port 0, all enables, reserved bits zero
    send_cmd(32'h04003c3e);
    wait_fetch(5'h00, 10'h03e, 4'hf);
    m.stop();
    m.start();
    read_back(word_of(5'h00, 10'h03e), 6);
    m.stop();
    // non-read opcode: acked, never fetched
    prev = req_cnt;
    send_cmd(32'h03003c3e);
    m.stop();
    for (int n = 0; n < 40 && cmd_unsupported !== 1'b1; n++) @(negedge clk);
    check("unsupported_set", cmd_unsupported, 1'b1);
    check("no_fetch", req_cnt, prev);
    // merged packet, reserved bits set, port 0bh, partial enables
    send_cmd(32'hf4f5d69b);
    wait_fetch(5'h0b, 10'h29b, 4'h5);
    check("unsupported_clr", cmd_unsupported, 1'b0);
    m.start();
    read_back(word_of(5'h0b, 10'h29b), 4);
    m.stop();
    // merged read that outruns the fetch gets fill bytes; the fetch still completes
    send_cmd(32'h04003c3e);
    m.start();
    read_back({4{i2crd_pkg::FILL_BYTE}}, 2);
    m.stop();
    wait_fetch(5'h00, 10'h03e, 4'hf);
    // select pins move the low address bits; scl is still while they change
    for (int s = 1; s < 8; s += 6) begin
      addr_sel = s[2:0];
      m.start();
      m.addr_byte(7'h68, 1'b0, ack);
      check("base_addr_moved", ack, 1'b0);
      m.start();
      m.addr_byte({4'hd, s[2:0]}, 1'b0, ack);
      check("sel_addr_ack", ack, 1'b1);
      m.stop();
    end
    final_report();
  end
endmodule : i2crd_slave_bench
